// *** inc/iocd_regs.svh ***
// register map, field positions and reset values of the io cell block
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
`ifndef IOCD_REGS_SVH
`define IOCD_REGS_SVH
// sizes
`define IOCD_NCELL 4
`define IOCD_NDEC 4
`define IOCD_NDEC_RED 2
`define IOCD_DIN 8
`define IOCD_CFG_W 14
`define IOCD_DEC_W 17
// bank numbers and byte offsets; cells and decoders take one word each in a bank
`define IOCD_CELL_BANK 4'h0
`define IOCD_DEC_BANK 4'h1
`define IOCD_CTRL 8'h20
`define IOCD_STAT 8'h24
// address fields: bank, word index within the bank, byte alignment
`define IOCD_F_BANK 7:4
`define IOCD_F_IDX 3:2
`define IOCD_F_ALIGN 1:0
// cell word fields
`define IOCD_F_SRC 1:0
`define IOCD_F_INIT 2
`define IOCD_F_OCLK 3
`define IOCD_F_ICLK 4
`define IOCD_F_TSLOW 5
`define IOCD_F_PULL 7:6
`define IOCD_F_PFIRST 9:8
`define IOCD_F_PSECOND 11:10
`define IOCD_F_FAST 12
`define IOCD_F_TSUSE 13
// decoder word fields
`define IOCD_F_USE 7:0
`define IOCD_F_INV 15:8
`define IOCD_F_SPLIT 16
// control word fields
`define IOCD_F_CONF 0
`define IOCD_F_GSR 1
`define IOCD_F_RED 2
// reset values
`define IOCD_CFG_RST 14'h0000
`define IOCD_DEC_RST 17'h00000
`define IOCD_CONF_RST 1'b1
`define IOCD_RED_RST 1'b0
`endif

// *** inc/iocd_pkg.sv ***
// selection types shared by the io cell and its top
// assumes encodings match the two-bit fields of the cell word
package iocd_pkg;
  typedef enum logic [1:0] {
    iocd_src_direct, iocd_src_invert, iocd_src_flop, iocd_src_decode
  } iocd_out_src_t;
  typedef enum logic [1:0] {
    iocd_pull_none, iocd_pull_up, iocd_pull_down, iocd_pull_rsvd
  } iocd_pull_t;
  typedef enum logic [1:0] {
    iocd_in_raw, iocd_in_master, iocd_in_slave, iocd_in_rsvd
  } iocd_in_src_t;
endpackage

// *** hw/iocd_cell.sv ***
// one configurable input/output cell
// assumes pad and cell clocks arrive unsynchronised; config is static
`timescale 1ns/1ps
`include "iocd_regs.svh"
module iocd_cell (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration
  input wire logic [`IOCD_CFG_W-1:0] cfg,
  input wire logic configuring,
  input wire logic init_load,
  // fabric side
  input wire logic core_out,
  input wire logic core_ts,
  input wire logic in_clk,
  input wire logic out_clk,
  input wire logic dec_val,
  output logic path_first,
  output logic path_second,
  // pad side
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup,
  output logic pad_pulldown
);
  logic pad_s1, pad_s2, pad_dly, ic_s1, ic_s2, oc_s1, oc_s2;
  logic ic_eff_d, oc_eff_d, master, slave, out_ff;
  logic ic_eff, oc_eff;

  ////////////////////////////////////////////////////////////////////
  // synchronisers; input and output flops have their own clocks
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {pad_s1, pad_s2, pad_dly} <= 3'h0;
      {ic_s1, ic_s2, oc_s1, oc_s2} <= 4'h0;
      {ic_eff_d, oc_eff_d} <= 2'h0;
    end else begin
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
      pad_dly <= pad_s2;
      ic_s1 <= in_clk;
      ic_s2 <= ic_s1;
      oc_s1 <= out_clk;
      oc_s2 <= oc_s1;
      ic_eff_d <= ic_eff;
      oc_eff_d <= oc_eff;
    end
  end

  // polarity select turns a falling edge into an effective rising one
  assign ic_eff = ic_s2 ^ cfg[`IOCD_F_ICLK];
  assign oc_eff = oc_s2 ^ cfg[`IOCD_F_OCLK];
  wire ic_rise = ic_eff & ~ic_eff_d;
  wire oc_rise = oc_eff & ~oc_eff_d;
  // default path carries the extra delay stage; fast attribute skips it
  wire in_d = cfg[`IOCD_F_FAST] ? pad_s2 : pad_dly;
  wire init_val = cfg[`IOCD_F_INIT];

  ////////////////////////////////////////////////////////////////////
  // master is transparent while the effective clock is low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {master, slave, out_ff} <= 3'h0;
    end else if (init_load) begin
      master <= init_val;
      slave <= init_val;
      out_ff <= init_val;
    end else begin
      if (!ic_eff) master <= in_d;
      if (ic_rise) slave <= master;
      if (oc_rise) out_ff <= core_out;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output source, driver enable and pulls
  wire [1:0] src = cfg[`IOCD_F_SRC];
  wire [1:0] pull = cfg[`IOCD_F_PULL];
  wire ts_off = core_ts ^ cfg[`IOCD_F_TSLOW];
  assign pad_out = (src == iocd_pkg::iocd_src_direct) ? core_out :
    (src == iocd_pkg::iocd_src_invert) ? ~core_out :
    (src == iocd_pkg::iocd_src_flop) ? out_ff : dec_val;
  assign pad_oe = ~configuring &
    ~(cfg[`IOCD_F_TSUSE] & ts_off);
  // configuration forces a pull-up over the user choice
  assign pad_pullup = configuring |
    (pull == iocd_pkg::iocd_pull_up);
  assign pad_pulldown = ~configuring &
    (pull == iocd_pkg::iocd_pull_down);

  ////////////////////////////////////////////////////////////////////
  // two fabric outputs, each with its own source select
  wire [1:0] s1 = cfg[`IOCD_F_PFIRST];
  wire [1:0] s2 = cfg[`IOCD_F_PSECOND];
  assign path_first = (s1 == iocd_pkg::iocd_in_master) ? master :
    (s1 == iocd_pkg::iocd_in_slave) ? slave : pad_s2;
  assign path_second = (s2 == iocd_pkg::iocd_in_master) ? master :
    (s2 == iocd_pkg::iocd_in_slave) ? slave : pad_s2;
endmodule

// *** hw/iocd_top.sv ***
// io cells of one chip edge, their wide decoders and an apb slave
// assumes one 10 mhz clock; pads and cell clocks are asynchronous
// Contract
// - output fed by core signal, its inverse, or its flopped copy
// - cell flops start in configured init state when operational
// - global set/reset after configuration forces init state
// - each cell flop picks rising or falling clock edge
// - active level of the 3-state control is configurable
// - pad takes pull-up, pull-down or no resistor
// - during configuration every pad gets a pull-up
// - pad input feeds fabric and input flop data
// - two fabric outputs each pick raw pad, master or slave
// - input path delay by default, removed by fast attribute
// - four decoders per edge, two in reduced variant
// - decoder inputs are first input paths plus local lines
// - decoder high when AND of chosen true/inverted inputs holds
// - each decoder splits into two independent halves
// - decoder results go to fabric and to output pads
// - input and output flops have separate clocks
// - optional output enable puts driver in high impedance
`timescale 1ns/1ps
`include "iocd_regs.svh"
module iocd_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fabric side
  input wire logic [`IOCD_NCELL-1:0] core_out,
  input wire logic [`IOCD_NCELL-1:0] core_ts,
  input wire logic [`IOCD_NCELL-1:0] in_clk,
  input wire logic [`IOCD_NCELL-1:0] out_clk,
  input wire logic [`IOCD_NCELL-1:0] core_local,
  output logic [`IOCD_NCELL-1:0] input_path_first,
  output logic [`IOCD_NCELL-1:0] input_path_second,
  output logic [2*`IOCD_NDEC-1:0] dec_to_core,
  // pads
  input wire logic [`IOCD_NCELL-1:0] pad_in,
  output logic [`IOCD_NCELL-1:0] pad_out,
  output logic [`IOCD_NCELL-1:0] pad_oe,
  output logic [`IOCD_NCELL-1:0] pad_pullup,
  output logic [`IOCD_NCELL-1:0] pad_pulldown
);
  logic [`IOCD_CFG_W-1:0] cell_cfg [`IOCD_NCELL];
  logic [`IOCD_DEC_W-1:0] dec_cfg [`IOCD_NDEC];
  logic configuring, reduced, conf_d, gsr_req, err_q;
  logic [`IOCD_NDEC-1:0] dec_full;

  ////////////////////////////////////////////////////////////////////
  // apb decode; writes land at the access edge only
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire [3:0] bank = paddr[`IOCD_F_BANK];
  wire [1:0] idx = paddr[`IOCD_F_IDX];
  wire aligned = (paddr[`IOCD_F_ALIGN] == 2'h0);
  wire hit_cell = aligned & (bank == `IOCD_CELL_BANK);
  wire hit_dec = aligned & (bank == `IOCD_DEC_BANK);
  wire hit_ctrl = (paddr == `IOCD_CTRL);
  wire hit_stat = (paddr == `IOCD_STAT);
  wire hit_any = hit_cell | hit_dec | hit_ctrl | hit_stat;
  wire wr_ctrl = wr_en & hit_ctrl;
  wire next_conf = wr_ctrl ? pwdata[`IOCD_F_CONF] : configuring;
  // a set/reset request while configuring is dropped
  wire next_gsr = wr_ctrl & pwdata[`IOCD_F_GSR] & ~configuring;
  // init state loads on leaving configuration or on set/reset
  wire init_load = gsr_req | (conf_d & ~configuring);

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < `IOCD_NCELL; i++) cell_cfg[i] <= `IOCD_CFG_RST;
      for (int i = 0; i < `IOCD_NDEC; i++) dec_cfg[i] <= `IOCD_DEC_RST;
    end else if (wr_en & hit_cell) begin
      cell_cfg[idx] <= pwdata[`IOCD_CFG_W-1:0];
    end else if (wr_en & hit_dec) begin
      dec_cfg[idx] <= pwdata[`IOCD_DEC_W-1:0];
    end
  end

  // control; device comes out of reset in the configuring state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      configuring <= `IOCD_CONF_RST;
      conf_d <= `IOCD_CONF_RST;
      reduced <= `IOCD_RED_RST;
      gsr_req <= 1'b0;
    end else begin
      configuring <= next_conf;
      conf_d <= configuring;
      gsr_req <= next_gsr;
      if (wr_ctrl) reduced <= pwdata[`IOCD_F_RED];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data is captured in the setup cycle so prdata is a flop
  wire [31:0] cell_rd = {18'h0, cell_cfg[idx]};
  wire [31:0] dec_rd = {15'h0, dec_cfg[idx]};
  wire [31:0] ctrl_rd = {29'h0, reduced, 1'b0, configuring};
  wire [31:0] stat_rd = {12'h0, dec_full, dec_to_core,
    input_path_second, input_path_first};
  wire [31:0] rd_val = hit_cell ? cell_rd : hit_dec ? dec_rd :
    hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rd_val;
      err_q <= ~hit_any;
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;

  ////////////////////////////////////////////////////////////////////
  // cells; each pad can show its own decoder's lower half result
  for (genvar c = 0; c < `IOCD_NCELL; c++) begin : g_cell
    iocd_cell u_cell (
      .clk_sys(clk_sys),
      .rst(rst),
      .cfg(cell_cfg[c]),
      .configuring(configuring),
      .init_load(init_load),
      .core_out(core_out[c]),
      .core_ts(core_ts[c]),
      .in_clk(in_clk[c]),
      .out_clk(out_clk[c]),
      .dec_val(dec_to_core[2*c]),
      .path_first(input_path_first[c]),
      .path_second(input_path_second[c]),
      .pad_in(pad_in[c]),
      .pad_out(pad_out[c]),
      .pad_oe(pad_oe[c]),
      .pad_pullup(pad_pullup[c]),
      .pad_pulldown(pad_pulldown[c])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // wide decoders; unused inputs count as true in the AND
  wire [`IOCD_DIN-1:0] dec_in = {core_local, input_path_first};
  localparam int HALF = `IOCD_DIN / 2;
  for (genvar d = 0; d < `IOCD_NDEC; d++) begin : g_dec
    wire [`IOCD_DIN-1:0] use_m = dec_cfg[d][`IOCD_F_USE];
    wire [`IOCD_DIN-1:0] inv_m = dec_cfg[d][`IOCD_F_INV];
    wire [`IOCD_DIN-1:0] term = ~use_m | (dec_in ^ inv_m);
    // the reduced variant keeps only the lower decoders alive
    wire live = ~reduced | (d < `IOCD_NDEC_RED);
    wire split = dec_cfg[d][`IOCD_F_SPLIT];
    wire lo = &term[HALF-1:0];
    wire hi = &term[`IOCD_DIN-1:HALF];
    assign dec_full[d] = live & lo & hi;
    assign dec_to_core[2*d] = live & (split ? lo : lo & hi);
    assign dec_to_core[2*d+1] = live & (split ? hi : lo & hi);
  end

  ////////////////////////////////////////////////////////////////////
  // checks on the cells, the decoders and the apb slave
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [1:0] src0 = cell_cfg[0][`IOCD_F_SRC];
  wire [1:0] src1 = cell_cfg[1][`IOCD_F_SRC];
  wire [1:0] src2 = cell_cfg[2][`IOCD_F_SRC];
  wire [1:0] i10 = cell_cfg[0][`IOCD_F_PFIRST];
  wire [1:0] pull2 = cell_cfg[2][`IOCD_F_PULL];

  property p_src_direct;
    src0 == iocd_pkg::iocd_src_direct |-> pad_out[0] == core_out[0];
  endproperty
  a_src_direct: assert property (p_src_direct)
    else $error("direct source does not reach pad");

  property p_src_invert;
    src1 == iocd_pkg::iocd_src_invert |-> pad_out[1] != core_out[1];
  endproperty
  a_src_invert: assert property (p_src_invert)
    else $error("inverted source does not reach pad");

  property p_gsr_init;
    gsr_req && src2 == iocd_pkg::iocd_src_flop
      |=> pad_out[2] == $past(cell_cfg[2][`IOCD_F_INIT]);
  endproperty
  a_gsr_init: assert property (p_gsr_init)
    else $error("set/reset did not restore init state");

  property p_op_init;
    $fell(configuring) ##1 src2 == iocd_pkg::iocd_src_flop
      |=> pad_out[2] == $past(cell_cfg[2][`IOCD_F_INIT], 2);
  endproperty
  a_op_init: assert property (p_op_init)
    else $error("flop not in init state after configuration");

  property p_conf_pull;
    configuring |-> pad_pullup == 4'hf && pad_pulldown == 4'h0
      && pad_oe == 4'h0;
  endproperty
  a_conf_pull: assert property (p_conf_pull)
    else $error("pull-up missing while configuring");

  property p_pull_sel;
    !configuring && pull2 == iocd_pkg::iocd_pull_down
      |-> pad_pulldown[2] && !pad_pullup[2];
  endproperty
  a_pull_sel: assert property (p_pull_sel)
    else $error("pull-down choice not applied");

  property p_ts_level;
    !configuring && cell_cfg[0][`IOCD_F_TSUSE]
      |-> pad_oe[0] == (core_ts[0] == cell_cfg[0][`IOCD_F_TSLOW]);
  endproperty
  a_ts_level: assert property (p_ts_level)
    else $error("driver enable ignores 3-state polarity");

  property p_raw_path;
    // the synchroniser holds reset zeros for two edges after release
    !$past(rst) && i10 == iocd_pkg::iocd_in_raw && $stable(i10)
      ##1 $stable(i10)
      |-> input_path_first[0] == $past(pad_in[0], 2);
  endproperty
  a_raw_path: assert property (p_raw_path)
    else $error("raw input path is not the pad two cycles back");

  property p_reduced;
    reduced |-> dec_to_core[2*`IOCD_NDEC-1:2*`IOCD_NDEC_RED] == 4'h0;
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("reduced variant drives upper decoders");

  property p_dec_and;
    !reduced && dec_cfg[2][`IOCD_F_USE] == 8'hf0
      && dec_cfg[2][`IOCD_F_INV] == 8'h00
      |-> dec_full[2] == &core_local;
  endproperty
  a_dec_and: assert property (p_dec_and)
    else $error("decoder AND does not follow its input");

  property p_unmapped;
    setup && !hit_any |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

  c_gsr: cover property (gsr_req ##1 pad_out[2]);
  c_split: cover property (dec_cfg[0][`IOCD_F_SPLIT]
    && dec_to_core[0] != dec_to_core[1]);
  c_tristate: cover property (!configuring && !pad_oe[0]);
endmodule

// *** verif/iocd_board.sv ***
// board model at the pads: resolves every pin from all its drivers
// assumes pad_oe high means the cell drives its pin
`timescale 1ns/1ps
`include "iocd_regs.svh"
module iocd_board (
  // clock
  input wire logic clk_sys,
  // cell side of the pins
  input wire logic [`IOCD_NCELL-1:0] pad_out,
  input wire logic [`IOCD_NCELL-1:0] pad_oe,
  input wire logic [`IOCD_NCELL-1:0] pad_pullup,
  input wire logic [`IOCD_NCELL-1:0] pad_pulldown,
  // board drivers, steered by the bench
  input wire logic [`IOCD_NCELL-1:0] drv_en,
  input wire logic [`IOCD_NCELL-1:0] drv_val,
  output logic [`IOCD_NCELL-1:0] pad_in
);
  logic [`IOCD_NCELL-1:0] float_pat = 4'h5;
  ////////////////////////////////////////////////////////////////////////
  // a pin nobody holds wanders, so a stale level never passes for valid
  always @(posedge clk_sys) begin
    float_pat <= ~float_pat;
  end
  // cell driver first, then board driver, then the pull resistors
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv_val) |
    (~pad_oe & ~drv_en & (pad_pullup | (~pad_pulldown & float_pat)));
endmodule

// *** verif/iocd_top_test.sv ***
// self-checking bench for the io cells, decoders and register slave
// assumes the board model above and the apb timing of the slave
`timescale 1ns/1ps
`include "iocd_regs.svh"
module iocd_top_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [3:0] core_out = 4'h0, core_ts = 4'h0, core_local = 4'h0;
  logic [3:0] in_clk = 4'h0, out_clk = 4'h0;
  logic [3:0] drv_en = 4'h0, drv_val = 4'h0, e_oe;
  logic [3:0] input_path_first, input_path_second, pad_in, pad_out;
  logic [3:0] pad_oe, pad_pullup, pad_pulldown;
  logic [7:0] dec_to_core;
  logic [15:0] v;
  int bad_count = 0, n_compared = 0;

  always #50 clk_sys = ~clk_sys;

  iocd_top iocd_top_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_out, .core_ts, .in_clk,
    .out_clk, .core_local, .input_path_first, .input_path_second,
    .dec_to_core, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_pulldown);
  iocd_board iocd_board_i (.clk_sys, .pad_out, .pad_oe, .pad_pullup,
    .pad_pulldown, .drv_en, .drv_val, .pad_in);

  ////////////////////////////////////////////////////////////////////////
  // verdict and counts, the single exit of the run
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one comparison, case equality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) begin
      bad_count++;
      close_out;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let a few clocks pass, then look where outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    close_out;
  end
  // main sequence
  initial begin
    void'($urandom(32'h2534));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    settle(0);
    chk("pullup", pad_pullup, 4'hf);
    chk("oe", pad_oe, 4'h0);
    apb(1'b0, `IOCD_CTRL, 32'h0, rd, er);
    chk("ctrl", rd, 32'h1);
    apb(1'b0, 8'h30, 32'h0, rd, er);
    chk("unmapped", er, 1'b1);
    // gated direct, inverted pull-up, flop set pull-down, plain direct
    apb(1'b1, 8'h00, 32'h2000, rd, er);
    apb(1'b1, 8'h04, 32'h0041, rd, er);
    apb(1'b1, 8'h08, 32'h0086, rd, er);
    apb(1'b1, 8'h0c, 32'h0000, rd, er);
    apb(1'b1, 8'h10, 32'h50f0, rd, er);
    apb(1'b1, 8'h14, 32'h10018, rd, er);
    apb(1'b1, 8'h18, 32'h00f0, rd, er);
    settle(0);
    chk("pullup cfg", pad_pullup, 4'hf);
    apb(1'b1, `IOCD_CTRL, 32'h0, rd, er);
    settle(4);
    chk("pullup", pad_pullup, 4'h2);
    chk("pulldown", pad_pulldown, 4'h4);
    chk("init", pad_out[2], 1'b1);
    // both 3-state polarities, random traffic with corner decodes
    for (int pol = 0; pol < 2; pol++) begin
      apb(1'b1, 8'h00, 32'h2000 | (pol << 5), rd, er);
      for (int i = 0; i < 12; i++) begin
        v = 16'($urandom);
        if (i == 0) v[11:8] = 4'ha;
        if (i == 1) v[11:8] = 4'hf;
        e_oe = {3'b111, v[4] == pol[0]};
        @(posedge clk_sys);
        core_out <= v[3:0];
        core_ts <= v[7:4];
        core_local <= v[11:8];
        drv_val <= v[15:12];
        drv_en <= ~e_oe;
        settle(4);
        chk("pad_out", pad_out[1:0], {~v[1], v[0]});
        chk("pad_oe", pad_oe, e_oe);
        chk("first", {input_path_first[3], input_path_first[0]},
          {v[3], e_oe[0] ? v[0] : v[12]});
        chk("dec", dec_to_core[5:0], {{2{&v[11:8]}}, v[8], v[3],
          {2{&(v[11:8] ^ 4'h5)}}});
      end
    end
    // reduced variant silences the upper decoders
    @(posedge clk_sys);
    core_local <= 4'hf;
    settle(1);
    chk("full", dec_to_core[5:4], 2'b11);
    apb(1'b1, `IOCD_CTRL, 32'h4, rd, er);
    settle(1);
    chk("reduced", dec_to_core[7:4], 4'h0);
    // output flop: rising capture, global set/reset, then falling capture
    @(posedge clk_sys);
    core_out <= 4'h0;
    settle(4);
    @(posedge clk_sys);
    out_clk <= 4'h4;
    settle(6);
    chk("rise cap", pad_out[2], 1'b0);
    apb(1'b1, `IOCD_CTRL, 32'h2, rd, er);
    settle(3);
    chk("gsr", pad_out[2], 1'b1);
    apb(1'b1, 8'h08, 32'h008e, rd, er);
    settle(4);
    @(posedge clk_sys);
    out_clk <= 4'h0;
    settle(6);
    chk("fall cap", pad_out[2], 1'b0);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk("cfg read", rd, 32'h008e);
    chk("read err", er, 1'b0);
    // input flop on cell 3: master open while its clock is low, slave
    // loads on the rising edge; the fast attribute saves one stage
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, 8'h0c, 32'h0900 | (f << 12), rd, er);
      @(posedge clk_sys);
      core_out <= 4'h8;
      settle(3);
      chk("master early", input_path_first[3], f);
      settle(1);
      chk("master", input_path_first[3], 1'b1);
      chk("slave held", input_path_second[3], 1'b0);
      @(posedge clk_sys);
      in_clk <= 4'h8;
      settle(4);
      chk("slave", input_path_second[3], 1'b1);
      @(posedge clk_sys);
      core_out <= 4'h0;
      settle(5);
      chk("master shut", input_path_first[3], 1'b1);
      @(posedge clk_sys);
      in_clk <= 4'h0;
      settle(5);
      chk("master open", input_path_first[3], 1'b0);
      chk("slave keep", input_path_second[3], 1'b1);
      @(posedge clk_sys);
      in_clk <= 4'h8;
      settle(4);
      chk("slave low", input_path_second[3], 1'b0);
      @(posedge clk_sys);
      in_clk <= 4'h0;
      settle(4);
    end
    // decoder result routed straight to a pad
    apb(1'b1, 8'h00, 32'h0003, rd, er);
    @(posedge clk_sys);
    core_local <= 4'ha;
    settle(1);
    chk("dec pad", pad_out[0], 1'b1);
    @(posedge clk_sys);
    core_local <= 4'hf;
    settle(1);
    chk("dec pad", pad_out[0], 1'b0);
    close_out;
  end
endmodule
